// File: rtl/uart_line_modem_status.v
// Modem control, line status, modem status, scratch and enhanced mode select logic of one UART channel.
//
// Contract
// - In loopback the internal ring input takes the user output one control bit.
// - In 16 mode interrupt pin floats when mode pin and enable bit are both 0.
// - In loopback internal user output two follows the interrupt enable bit.
// - Loopback bit set enters local loopback; cleared, the default, gives normal line.
// - Xon-any resumes halted transmitter on any character; flow characters are not stored.
// - Infrared bit routes data via IrDA coder; infrared output stays 0 when idle.
// - Prescaler bit loads strap at reset, stays writable; 1 divides clock by four.
// - Line status bits 1-4 with line interrupt enable raise the interrupt one clock later.
// - Character arriving at full FIFO flags overrun and is dropped, FIFO untouched.
// - Parity and framing flags describe the character at the receive FIFO head.
// - Line low one frame flags break, stores one break character, holds till high.
// - Holding-empty sets on move to shifter, clears on host load; FIFO mode: empty.
// - Transmitter-empty is 1 only when holding side and shift register are empty.
// - FIFO error flag is set while any stored byte carries an error tag.
// - CTS, DSR, CD deltas set on any change; modem interrupt when enabled.
// - Ring delta sets only on ring pin going from 0 to 1.
// - Auto CTS: pin 1 stops after current character, pin 0 resumes.
// - Modem status 4-7 are inverted pins, or RTS, DTR, out one, enable in loopback.
// - Scratch register is 8 bits and resets to all ones.
// - Swap mode: scratch writes go to mode select; low bits pick counter read.
// - Alternating mode: first read gives receive count, then transmit and receive alternate.
`timescale 1ns/1ps
`include "uart_lms_defines.vh"

// ==================================================
// Receive buffer
module rx_tag_fifo #(
    parameter WIDTH = 11,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    input  wire             clk_sys_i,
    input  wire             reset_i,
    input  wire             in_valid_i,
    output wire             in_ready_o,
    input  wire [WIDTH-1:0] in_data_i,
    output wire             out_valid_o,
    input  wire             out_ready_i,
    output wire [WIDTH-1:0] out_data_o,
    output reg  [AW:0]      count_o
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    wire            push;
    wire            pop;

    assign in_ready_o  = (count_o != DEPTH[AW:0]);
    assign out_valid_o = (count_o != {(AW+1){1'b0}});
    assign out_data_o  = mem[rd_ptr];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always @(posedge clk_sys_i) begin
        if (reset_i) begin
            wr_ptr  <= {AW{1'b0}};
            rd_ptr  <= {AW{1'b0}};
            count_o <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                mem[wr_ptr] <= in_data_i;
                wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1 && DEPTH != (1 << AW)) ? {AW{1'b0}} : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1 && DEPTH != (1 << AW)) ? {AW{1'b0}} : rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count_o <= count_o + 1'b1;
            end else if (pop && !push) begin
                count_o <= count_o - 1'b1;
            end
        end
    end
endmodule // rx_tag_fifo

// ==================================================
// Channel status block
module uart_line_modem_status #(
    parameter FIFO_DEPTH   = 4,
    parameter FIFO_AW      = 2,
    parameter FRAME_CYCLES = `FRAME_CYCLES
) (
    input  wire       clk_sys_i,
    input  wire       reset_i,
    input  wire [2:0] addr_i,
    input  wire       cs_i,
    input  wire       rd_i,
    input  wire       wr_i,
    input  wire [7:0] wr_data_i,
    output reg  [7:0] rd_data_o,
    input  wire [3:0] irq_enable_reg_i,
    input  wire [7:0] feature_ctl_reg_i,
    input  wire [7:0] enh_feature_reg_i,
    input  wire       bus_mode_16_i,
    input  wire       irq_mode_pin_i,
    input  wire       prescale_strap_i,
    input  wire       cts_n_i,
    input  wire       dsr_n_i,
    input  wire       bell_detect_in_i,
    input  wire       carrier_detect_in_i,
    input  wire       rx_pin_i,
    input  wire       rx_char_valid_i,
    input  wire [7:0] rx_char_i,
    input  wire       rx_parity_err_i,
    input  wire       rx_frame_err_i,
    input  wire       rx_flow_char_i,
    input  wire       tx_halted_i,
    input  wire       serial_tx_i,
    input  wire       tx_idle_i,
    input  wire       ir_pulse_i,
    input  wire       fifo_mode_i,
    input  wire       tx_to_shift_i,
    input  wire       tx_fifo_empty_i,
    input  wire       tx_shift_empty_i,
    input  wire [7:0] tx_fifo_count_i,
    input  wire       rs485_dir_i,
    output wire       rx_ready_o,
    output reg        tx_o,
    output reg        ir_tx_o,
    output reg        rx_serial_o,
    output reg        ir_route_o,
    output reg        dtr_n_o,
    output reg        rts_n_o,
    output reg        user_out_one_o,
    output reg        user_out_two_o,
    output reg        tx_resume_o,
    output reg        tx_start_ok_o,
    output reg        baud_tick_o,
    output reg        irq_o,
    output reg        irq_oe_n_o
);
    // ==================================================
    // Pin synchronisers; the strap chain is left out of reset so it is valid during reset.
    reg [1:0] cts_sync;
    reg [1:0] dsr_sync;
    reg [1:0] ri_sync;
    reg [1:0] cd_sync;
    reg [1:0] rx_sync;
    reg [1:0] sel_sync;
    reg [1:0] strap_sync;

    always @(posedge clk_sys_i) begin
        cts_sync   <= {cts_sync[0], cts_n_i};
        dsr_sync   <= {dsr_sync[0], dsr_n_i};
        ri_sync    <= {ri_sync[0], bell_detect_in_i};
        cd_sync    <= {cd_sync[0], carrier_detect_in_i};
        rx_sync    <= {rx_sync[0], rx_pin_i};
        sel_sync   <= {sel_sync[0], irq_mode_pin_i};
        strap_sync <= {strap_sync[0], prescale_strap_i};
    end

    // ==================================================
    // Register state
    reg  [7:0]           modem_ctl_reg;
    reg  [7:0]           scratch_reg;
    reg  [7:0]           enh_mode_sel_reg;
    reg                  alt_tx_next;
    reg  [3:0]           msr_delta;
    reg  [3:0]           modem_prev;
    reg                  overrun;
    reg                  thr_empty;
    reg  [15:0]          low_count;
    reg                  break_hold;
    reg  [FIFO_AW:0]     err_count;
    reg  [1:0]           pre_count;
    wire                 loop;
    wire                 wr_en;
    wire                 rd_en;
    wire [3:0]           modem_in;
    wire [7:0]           line_stat_reg;
    wire [7:0]           modem_stat_reg;
    wire                 fifo_in_ready;
    wire                 fifo_out_valid;
    wire [10:0]          fifo_head;
    wire [FIFO_AW:0]     fifo_count;
    wire                 pop;
    wire                 store_char;
    wire                 break_start;
    wire                 push_valid;
    wire [10:0]          push_word;
    wire                 push_err;
    wire                 pop_err;
    wire [7:0]           rx_count;

    function [7:0] widen_count;
        input [FIFO_AW:0] c;
        begin
            widen_count = {{(7-FIFO_AW){1'b0}}, c};
        end
    endfunction

    assign loop  = modem_ctl_reg[`MCR_LOOP];
    assign wr_en = cs_i && wr_i;
    assign rd_en = cs_i && rd_i;
    assign pop   = rd_en && addr_i == `OFS_RX_HOLD && fifo_out_valid;
    assign rx_count = widen_count(fifo_count);

    // Active-high modem inputs as the status register sees them: CTS, DSR, RI, CD.
    assign modem_in = loop ? {modem_ctl_reg[`MCR_IRQ_OE],
                              modem_ctl_reg[`MCR_OUT_ONE],
                              modem_ctl_reg[`MCR_DTR],
                              modem_ctl_reg[`MCR_RTS]}
                           : {~cd_sync[1], ~ri_sync[1], ~dsr_sync[1], ~cts_sync[1]};

    // ==================================================
    // Host register access
    always @(posedge clk_sys_i) begin
        if (reset_i) begin
            modem_ctl_reg    <= {strap_sync[1], `MCR_RESET};
            scratch_reg      <= `SCRATCH_RESET;
            enh_mode_sel_reg <= `ENH_MODE_SEL_REG_RESET;
            alt_tx_next      <= 1'b0;
            rd_data_o        <= 8'h00;
        end else begin
            if (wr_en && addr_i == `OFS_MODEM_CTL) begin
                modem_ctl_reg <= wr_data_i;
            end
            if (wr_en && addr_i == `OFS_SCRATCH) begin
                if (feature_ctl_reg_i[`FEATURE_CTL_REG_SWAP]) begin
                    enh_mode_sel_reg <= wr_data_i;
                    alt_tx_next      <= 1'b0;
                end else begin
                    scratch_reg <= wr_data_i;
                end
            end
            if (rd_en) begin
                case (addr_i)
                    `OFS_RX_HOLD:    rd_data_o <= fifo_out_valid ? fifo_head[7:0] : 8'h00;
                    `OFS_MODEM_CTL:  rd_data_o <= modem_ctl_reg;
                    `OFS_LINE_STAT:  rd_data_o <= line_stat_reg;
                    `OFS_MODEM_STAT: rd_data_o <= modem_stat_reg;
                    `OFS_SCRATCH: begin
                        if (!feature_ctl_reg_i[`FEATURE_CTL_REG_SWAP]) begin
                            rd_data_o <= scratch_reg;
                        end else begin
                            case (enh_mode_sel_reg[1:0])
                                `ENH_MODE_SEL_REG_CNT_TX:       rd_data_o <= tx_fifo_count_i;
                                `ENH_MODE_SEL_REG_CNT_ALTERNATE: begin
                                    rd_data_o   <= alt_tx_next ? tx_fifo_count_i : rx_count;
                                    alt_tx_next <= ~alt_tx_next;
                                end
                                default:            rd_data_o <= rx_count;
                            endcase
                        end
                    end
                    default:         rd_data_o <= 8'h00;
                endcase
            end
        end
    end

    // ==================================================
    // Receive path, break detection and error tags
    // A break only stores one character per low period, so the counter saturates.
    assign break_start = (low_count == FRAME_CYCLES[15:0] - 16'h0001) && !rx_sync[1];
    assign store_char  = rx_char_valid_i &&
                         !(rx_flow_char_i && enh_feature_reg_i[3:0] != 4'h0);
    assign push_valid  = store_char || break_start;
    assign push_word   = break_start ? {1'b1, 2'b00, 8'h00}
                                     : {1'b0, rx_frame_err_i, rx_parity_err_i, rx_char_i};
    assign push_err    = push_valid && fifo_in_ready && (push_word[10:8] != 3'b000);
    assign pop_err     = pop && (fifo_head[10:8] != 3'b000);
    assign rx_ready_o  = fifo_in_ready;

    rx_tag_fifo #(
        .WIDTH (11),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_rx_fifo (
        .clk_sys_i   (clk_sys_i),
        .reset_i     (reset_i),
        .in_valid_i  (push_valid),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (push_word),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (pop),
        .out_data_o  (fifo_head),
        .count_o     (fifo_count)
    );

    always @(posedge clk_sys_i) begin
        if (reset_i) begin
            low_count  <= 16'h0000;
            break_hold <= 1'b0;
            overrun    <= 1'b0;
            err_count  <= {(FIFO_AW+1){1'b0}};
        end else begin
            if (rx_sync[1]) begin
                low_count  <= 16'h0000;
                break_hold <= 1'b0;
            end else if (low_count != FRAME_CYCLES[15:0]) begin
                low_count <= low_count + 16'h0001;
                break_hold <= break_hold || break_start;
            end
            if (push_valid && !fifo_in_ready) begin
                overrun <= 1'b1;
            end else if (rd_en && addr_i == `OFS_LINE_STAT) begin
                overrun <= 1'b0;
            end
            if (push_err && !pop_err) begin
                err_count <= err_count + 1'b1;
            end else if (pop_err && !push_err) begin
                err_count <= err_count - 1'b1;
            end
        end
    end

    // ==================================================
    // Transmit status
    always @(posedge clk_sys_i) begin
        if (reset_i) begin
            thr_empty <= 1'b1;
        end else if (tx_to_shift_i) begin
            thr_empty <= 1'b1;
        end else if (wr_en && addr_i == `OFS_RX_HOLD) begin
            thr_empty <= 1'b0;
        end
    end

    assign line_stat_reg[0] = fifo_out_valid;
    assign line_stat_reg[1] = overrun;
    assign line_stat_reg[2] = fifo_out_valid && fifo_head[8];
    assign line_stat_reg[3] = fifo_out_valid && fifo_head[9];
    assign line_stat_reg[4] = (fifo_out_valid && fifo_head[10]) || break_hold;
    assign line_stat_reg[5] = fifo_mode_i ? tx_fifo_empty_i : thr_empty;
    assign line_stat_reg[6] = line_stat_reg[5] && tx_shift_empty_i;
    assign line_stat_reg[7] = (err_count != {(FIFO_AW+1){1'b0}});

    // ==================================================
    // Modem deltas
    assign modem_stat_reg = {modem_in, msr_delta};

    always @(posedge clk_sys_i) begin
        if (reset_i) begin
            msr_delta  <= 4'h0;
            modem_prev <= 4'h0;
        end else begin
            modem_prev <= modem_in;
            // A change in the read cycle is kept, so no edge is lost to the clear.
            msr_delta <= ({modem_in[3], 1'b0, modem_in[1:0]} ^ {modem_prev[3], 1'b0, modem_prev[1:0]}) |
                         {1'b0, modem_prev[2] && !modem_in[2], 2'b00} |
                         (msr_delta & {4{!(rd_en && addr_i == `OFS_MODEM_STAT)}});
        end
    end

    // ==================================================
    // Line side outputs, prescaler and interrupt pin
    always @(posedge clk_sys_i) begin
        if (reset_i) begin
            tx_o           <= 1'b1;
            ir_tx_o        <= 1'b0;
            rx_serial_o    <= 1'b1;
            ir_route_o     <= 1'b0;
            dtr_n_o        <= 1'b1;
            rts_n_o        <= 1'b1;
            user_out_one_o <= 1'b1;
            user_out_two_o <= 1'b1;
            tx_resume_o    <= 1'b0;
            tx_start_ok_o  <= 1'b1;
            baud_tick_o    <= 1'b0;
            pre_count      <= 2'h0;
            irq_o          <= 1'b0;
            irq_oe_n_o     <= 1'b1;
        end else begin
            ir_route_o  <= modem_ctl_reg[`MCR_IR_EN];
            tx_o        <= loop || modem_ctl_reg[`MCR_IR_EN] || serial_tx_i;
            ir_tx_o     <= !loop && modem_ctl_reg[`MCR_IR_EN] && !tx_idle_i && ir_pulse_i;
            rx_serial_o <= loop ? serial_tx_i : rx_sync[1];
            dtr_n_o     <= loop || !modem_ctl_reg[`MCR_DTR];
            rts_n_o     <= loop || !modem_ctl_reg[`MCR_RTS];
            if (feature_ctl_reg_i[`FEATURE_CTL_REG_RS485]) begin
                user_out_one_o <= rs485_dir_i;
            end else begin
                user_out_one_o <= loop || !modem_ctl_reg[`MCR_OUT_ONE];
            end
            // Loopback holds the pin inactive; the enable bit itself drives it internally.
            user_out_two_o <= loop || !modem_ctl_reg[`MCR_IRQ_OE];
            tx_resume_o    <= modem_ctl_reg[`MCR_XON_ANY] && tx_halted_i && rx_char_valid_i;
            // The transmitter samples this only between characters, so a stop lets the current one finish.
            tx_start_ok_o  <= !(enh_feature_reg_i[`EFR_AUTO_CTS] && cts_sync[1]);
            if (!modem_ctl_reg[`MCR_PRESCALE] || pre_count == `PRESCALE_DIV4) begin
                pre_count   <= 2'h0;
                baud_tick_o <= 1'b1;
            end else begin
                pre_count   <= pre_count + 2'h1;
                baud_tick_o <= 1'b0;
            end
            irq_o <= (irq_enable_reg_i[`IER_LINE_IRQ] && line_stat_reg[4:1] != 4'h0) ||
                     (irq_enable_reg_i[`IER_MODEM_IRQ] && msr_delta != 4'h0);
            irq_oe_n_o <= bus_mode_16_i && !sel_sync[1] && !modem_ctl_reg[`MCR_IRQ_OE];
        end
    end
endmodule // uart_line_modem_status

// File: rtl/uart_lms_defines.vh
// Register offsets, field positions, reset values and counts for the UART modem and line status block.
`ifndef UART_LMS_DEFINES_VH
`define UART_LMS_DEFINES_VH

// ==================================================
// Register offsets on the 3-bit host address
`define OFS_RX_HOLD         3'h0
`define OFS_MODEM_CTL       3'h4
`define OFS_LINE_STAT       3'h5
`define OFS_MODEM_STAT      3'h6
`define OFS_SCRATCH         3'h7

// ==================================================
// Modem control fields
`define MCR_DTR             0
`define MCR_RTS             1
`define MCR_OUT_ONE         2
`define MCR_IRQ_OE          3
`define MCR_LOOP            4
`define MCR_XON_ANY         5
`define MCR_IR_EN           6
`define MCR_PRESCALE        7

// ==================================================
// Other control fields seen on the side inputs
`define IER_LINE_IRQ        2
`define IER_MODEM_IRQ       3
`define FEATURE_CTL_REG_RS485          3
`define FEATURE_CTL_REG_SWAP           6
`define EFR_AUTO_CTS        7

// ==================================================
// Enhanced mode select counter modes
`define ENH_MODE_SEL_REG_CNT_RX         2'h0
`define ENH_MODE_SEL_REG_CNT_TX         2'h1
`define ENH_MODE_SEL_REG_CNT_RX_ALT     2'h2
`define ENH_MODE_SEL_REG_CNT_ALTERNATE  2'h3

// ==================================================
// Reset values and counts
`define SCRATCH_RESET       8'hff
`define MCR_RESET           7'h00
`define ENH_MODE_SEL_REG_RESET          8'h00
`define PRESCALE_DIV4       2'h3
`define FRAME_CYCLES        16'h00a0

`endif

// File: tb/remote_modem.sv
// Remote modem model that drives the line-side pins of the channel.
`timescale 1ns/1ps
module remote_modem (
    input  wire [3:0] lvl_i,
    input  wire       brk_i,
    output wire       cts_n_o,
    output wire       dsr_n_o,
    output wire       bell_n_o,
    output wire       carrier_n_o,
    output wire       rx_line_o
);
    assign {carrier_n_o, bell_n_o, dsr_n_o, cts_n_o} = lvl_i;
    // The line idles at mark and holds space for a whole break.
    assign rx_line_o = ~brk_i;
endmodule // remote_modem

// File: tb/test_uart_line_modem_status.sv
// Self-checking testbench for the channel status block.
`timescale 1ns/1ps
`include "uart_lms_defines.vh"
module test_uart_line_modem_status;
    reg         clk_sys_i = 1'b0;
    reg         reset_i   = 1'b1;
    reg  [2:0]  addr_i    = 3'h0;
    reg  [7:0]  wdat      = 8'h00;
    reg  [7:0]  rch       = 8'h00;
    reg  [7:0]  tcnt      = 8'h00;
    reg  [7:0]  d         = 8'h00;
    reg  [3:0]  lvl       = 4'hf;
    reg         cs_i = 1'b0, rd_i = 1'b0, wr_i = 1'b0, rcv = 1'b0, pe = 1'b0, brk = 1'b0, te = 1'b1;
    reg         ps = 1'b0, swap = 1'b0, acts = 1'b0, rd_seen = 1'b0;
    reg  [15:0] exp_q[$];
    reg  [15:0] ent;
    integer     seed = 32'h633d_fe3c, bad_count = 0, tests_run = 0, i, n;
    wire [7:0]  rd_data_o;
    wire        cts_n, dsr_n, bell_n, cd_n, rx_line, rx_ready_o, irq_o, tx_start_ok_o, baud_tick_o, tx_resume_o;
    always #2.5 clk_sys_i = ~clk_sys_i;
    remote_modem modem (.lvl_i(lvl), .brk_i(brk), .cts_n_o(cts_n), .dsr_n_o(dsr_n), .bell_n_o(bell_n),
        .carrier_n_o(cd_n), .rx_line_o(rx_line));
    // The RS-485 feature control bit stays low, so user output one follows its control bit.
    uart_line_modem_status #(.FRAME_CYCLES(20)) uut (
        .clk_sys_i(clk_sys_i), .reset_i(reset_i), .addr_i(addr_i), .cs_i(cs_i), .rd_i(rd_i), .wr_i(wr_i),
        .wr_data_i(wdat), .rd_data_o(rd_data_o), .irq_enable_reg_i(4'hc), .feature_ctl_reg_i({1'b0, swap, 6'h00}),
        .enh_feature_reg_i({acts, 7'h00}), .bus_mode_16_i(te), .irq_mode_pin_i(brk), .prescale_strap_i(ps),
        .cts_n_i(cts_n), .dsr_n_i(dsr_n), .bell_detect_in_i(bell_n), .carrier_detect_in_i(cd_n), .rx_pin_i(rx_line),
        .rx_char_valid_i(rcv), .rx_char_i(rch), .rx_parity_err_i(pe), .rx_frame_err_i(pe), .rx_flow_char_i(pe),
        .tx_halted_i(pe), .serial_tx_i(rch[0]), .tx_idle_i(te), .ir_pulse_i(rch[1]), .fifo_mode_i(te),
        .tx_to_shift_i(1'b0), .tx_fifo_empty_i(te), .tx_shift_empty_i(te), .tx_fifo_count_i(tcnt),
        .rs485_dir_i(1'b0), .rx_ready_o(rx_ready_o), .tx_o(), .ir_tx_o(), .rx_serial_o(), .ir_route_o(),
        .dtr_n_o(), .rts_n_o(), .user_out_one_o(), .user_out_two_o(), .tx_resume_o(tx_resume_o),
        .tx_start_ok_o(tx_start_ok_o), .baud_tick_o(baud_tick_o), .irq_o(irq_o), .irq_oe_n_o());
    task chk(input [7:0] seen, input [7:0] exp);
        begin
            tests_run = tests_run + 1;
            if (seen !== exp) begin
                bad_count = bad_count + 1;
                $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    // One register access; a read leaves its masked expectation for the monitor.
    task acc(input w, input [2:0] a, input [7:0] v, input [7:0] m);
        begin
            @(posedge clk_sys_i);
            cs_i <= 1'b1;
            rd_i <= !w;
            wr_i <= w;
            addr_i <= a;
            wdat <= v;
            if (!w) exp_q.push_back({m, v});
            @(posedge clk_sys_i);
            cs_i <= 1'b0;
            rd_i <= 1'b0;
            wr_i <= 1'b0;
        end
    endtask
    task push(input [7:0] c, input p);
        begin
            @(posedge clk_sys_i);
            rcv <= 1'b1;
            rch <= c;
            pe <= p;
            @(posedge clk_sys_i);
            rcv <= 1'b0;
        end
    endtask
    task idle(input integer k); repeat (k) @(posedge clk_sys_i); endtask
    task final_report;
        begin
            $display("comparisons %0d mismatches %0d", tests_run, bad_count);
            if (bad_count == 0 && tests_run > 0) begin
                $display("Test passed");
            end else begin
                $display("Test failed");
            end
            $finish;
        end
    endtask
    always @(posedge clk_sys_i) begin
        if (rd_seen) begin
            ent = exp_q.pop_front();
            chk(rd_data_o & ent[15:8], ent[7:0] & ent[15:8]);
        end
        rd_seen <= cs_i && rd_i;
    end
    // Eight thousand cycles is far beyond the whole sequence.
    initial begin
        #40000;
        bad_count = bad_count + 1;
        final_report;
    end
    initial begin
        ps = $random(seed);
        tcnt = $random(seed);
        idle(12);
        reset_i <= 1'b0;
        acc(0, `OFS_SCRATCH, `SCRATCH_RESET, 8'hff);
        acc(0, `OFS_MODEM_CTL, {ps, 7'h00}, 8'hff);
        acc(0, 3'h1, 8'h00, 8'hff);
        for (i = 0; i < 3; i = i + 1) begin
            d = $random(seed);
            acc(1, `OFS_SCRATCH, d, 8'h00);
            acc(0, `OFS_SCRATCH, d, 8'hff);
        end
        $display("registers done");
        for (i = 0; i < 5; i = i + 1) push(8'h30 + i[7:0], i == 0);
        chk({7'h00, rx_ready_o}, 8'h00);
        chk({7'h00, irq_o}, 8'h01);
        acc(0, `OFS_LINE_STAT, 8'hef, 8'hff);
        acc(0, `OFS_RX_HOLD, 8'h30, 8'hff);
        acc(0, `OFS_LINE_STAT, 8'h61, 8'hff);
        swap <= 1'b1;
        for (i = 0; i < 4; i = i + 1) begin
            acc(1, `OFS_SCRATCH, i[7:0], 8'h00);
            acc(0, `OFS_SCRATCH, (i == 1) ? tcnt : 8'h03, 8'hff);
        end
        acc(0, `OFS_SCRATCH, tcnt, 8'hff);
        acc(0, `OFS_SCRATCH, 8'h03, 8'hff);
        swap <= 1'b0;
        acc(0, `OFS_SCRATCH, d, 8'hff);
        for (i = 1; i < 4; i = i + 1) acc(0, `OFS_RX_HOLD, 8'h30 + i[7:0], 8'hff);
        acc(0, `OFS_LINE_STAT, 8'h60, 8'hff);
        $display("receive buffer done");
        brk <= 1'b1;
        idle(30);
        acc(0, `OFS_LINE_STAT, 8'hf1, 8'hff);
        brk <= 1'b0;
        idle(5);
        acc(0, `OFS_RX_HOLD, 8'h00, 8'hff);
        acc(0, `OFS_LINE_STAT, 8'h60, 8'hff);
        $display("break done");
        acc(0, `OFS_MODEM_STAT, 8'h00, 8'h00);
        lvl <= 4'hb;
        idle(6);
        acc(0, `OFS_MODEM_STAT, 8'h40, 8'hff);
        lvl <= 4'hf;
        idle(6);
        acc(0, `OFS_MODEM_STAT, 8'h04, 8'hff);
        lvl <= 4'he;
        idle(6);
        chk({7'h00, irq_o}, 8'h01);
        acc(0, `OFS_MODEM_STAT, 8'h11, 8'hff);
        acc(0, `OFS_MODEM_STAT, 8'h10, 8'hff);
        acts <= 1'b1;
        lvl <= 4'hf;
        idle(6);
        chk({7'h00, tx_start_ok_o}, 8'h00);
        lvl <= 4'he;
        idle(6);
        chk({7'h00, tx_start_ok_o}, 8'h01);
        $display("modem inputs done");
        acc(1, `OFS_MODEM_CTL, 8'h1f, 8'h00);
        acc(0, `OFS_MODEM_CTL, 8'h1f, 8'hff);
        acc(0, `OFS_MODEM_STAT, 8'hf0, 8'hf0);
        acc(1, `OFS_MODEM_CTL, 8'h10, 8'h00);
        acc(0, `OFS_MODEM_STAT, 8'h00, 8'hf0);
        acc(1, `OFS_MODEM_CTL, 8'h40, 8'h00);
        idle(4);
        for (i = 0; i < 2; i = i + 1) begin
            acc(1, `OFS_MODEM_CTL, (i == 0) ? 8'h80 : 8'h00, 8'h00);
            idle(4);
            n = 0;
            repeat (40) begin
                @(posedge clk_sys_i);
                n = n + baud_tick_o;
            end
            chk(n[7:0], (i == 0) ? 8'h0a : 8'h28);
        end
        acc(1, `OFS_MODEM_CTL, 8'h20, 8'h00);
        push(8'h41, 1'b1);
        @(negedge clk_sys_i) chk({7'h00, tx_resume_o}, 8'h01);
        $display("control modes done");
        final_report;
    end
endmodule // test_uart_line_modem_status

// File: tb/uart_lms_asserts.sv
// Concurrent checks on the ports of the channel status block.
`timescale 1ns/1ps
module uart_lms_asserts (
    input wire       clk_sys_i,
    input wire       reset_i,
    input wire [2:0] addr_i,
    input wire       cs_i,
    input wire       rd_i,
    input wire       wr_i,
    input wire [7:0] wr_data_i,
    input wire [7:0] rd_data_o,
    input wire [7:0] feature_ctl_reg_i,
    input wire       bus_mode_16_i,
    input wire       irq_mode_pin_i,
    input wire       tx_idle_i,
    input wire       tx_o,
    input wire       ir_tx_o,
    input wire       dtr_n_o,
    input wire       rts_n_o,
    input wire       irq_o,
    input wire       irq_oe_n_o
);
    // Shadow of the low control bits; bit 7 follows the strap and is left out.
    reg  [6:0] modem_control;
    wire       rd_sel = cs_i && rd_i;
    always @(posedge clk_sys_i) begin
        if (reset_i) modem_control <= 7'h00;
        else if (cs_i && wr_i && addr_i == 3'h4) modem_control <= wr_data_i[6:0];
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    a_read_holds: assert property (!rd_sel |=> $stable(rd_data_o)) else $error("read data moved");
    a_scratch_back: assert property (
        cs_i && wr_i && addr_i == 3'h7 && !feature_ctl_reg_i[6] ##2 rd_sel && addr_i == 3'h7 && !feature_ctl_reg_i[6]
        |=> rd_data_o == $past(wr_data_i, 3)) else $error("scratch readback wrong");
    a_ctl_back: assert property (
        cs_i && wr_i && addr_i == 3'h4 ##2 rd_sel && addr_i == 3'h4 |=> rd_data_o == $past(wr_data_i, 3))
        else $error("control readback wrong");
    a_reset_idle: assert property ($fell(reset_i) |-> tx_o && !irq_o && irq_oe_n_o) else $error("bad idle");
    a_loop_pins: assert property ($past(modem_control[4]) |-> tx_o && dtr_n_o && rts_n_o) else $error("loop pins");
    a_norm_pins: assert property (
        !$past(modem_control[4]) |-> dtr_n_o == !$past(modem_control[0]) && rts_n_o == !$past(modem_control[1])) else $error("modem pins");
    a_ir_idle: assert property ($past(modem_control[6]) && $past(tx_idle_i) |-> !ir_tx_o && tx_o) else $error("ir idle");
    a_irq_float: assert property (
        $past(bus_mode_16_i) && !$past(modem_control[3]) && !$past(irq_mode_pin_i) && !$past(irq_mode_pin_i, 2)
        && !$past(irq_mode_pin_i, 3) && !$past(irq_mode_pin_i, 4) |-> irq_oe_n_o) else $error("irq not floated");
    a_irq_drive: assert property ($past(modem_control[3]) |-> !irq_oe_n_o) else $error("irq not driven");
endmodule // uart_lms_asserts
bind uart_line_modem_status uart_lms_asserts u_chk (.clk_sys_i, .reset_i, .addr_i, .cs_i, .rd_i, .wr_i, .wr_data_i,
    .rd_data_o, .feature_ctl_reg_i, .bus_mode_16_i, .irq_mode_pin_i, .tx_idle_i, .tx_o, .ir_tx_o, .dtr_n_o, .rts_n_o,
    .irq_o, .irq_oe_n_o);
